//--- cch_far_model.sv
// far-side model: nonvolatile memory and analog front end
`timescale 1ns/1ps
module cch_far_model import cch_pkg::*; #(
	parameter int NV_WAIT   = 3,
	parameter int MEAS_WAIT = 4
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic nvReq,
	input  wire logic measStart,
	output logic      nvAck,
	output logic      measDone
);
	// acknowledge a write after a wait, held until the request has dropped
	initial begin
		nvAck = 1'b0;
		forever begin
			@(posedge mclk);
			#1;
			if (nvReq === 1'b1 && sys_rst === 1'b0) begin
				repeat (NV_WAIT) @(posedge mclk);
				#1 nvAck = 1'b1;
				@(posedge mclk);
				#1;
				while (nvReq === 1'b1) begin
					@(posedge mclk);
					#1;
				end
				nvAck = 1'b0;
			end
		end
	end

	// finish a measurement some cycles after it was started, one-cycle pulse
	initial begin
		measDone = 1'b0;
		forever begin
			@(posedge mclk);
			#1;
			if (measStart === 1'b1) begin
				repeat (MEAS_WAIT) @(posedge mclk);
				#1 measDone = 1'b1;
				@(posedge mclk);
				#1 measDone = 1'b0;
			end
		end
	end
endmodule // cch_far_model

//--- cch_handler.sv
// command decoder for identification writes, setup selection and raw measurements
`timescale 1ns/1ps
module cch_handler import cch_pkg::*; (
	input  wire logic      mclk,
	input  wire logic      sys_rst,
	input  wire logic      clkEn,
	input  wire cch_cmd_t  cmdIn,
	input  wire logic      cmdValid,
	output logic           cmdReady,
	output logic           cmdError,
	output cch_meas_t      measOut,
	output logic           measStart,
	input  wire logic      measDone,
	output logic           nvReq,
	output cch_nv_t        nvOut,
	input  wire logic      nvAck,
	output logic [15:0]    custIdLow,
	output logic [15:0]    custIdHigh,
	output logic [15:0]    primarySetup,
	output logic [15:0]    alternateSetup,
	output logic [15:0]    activeSetupWord,
	output logic           altSelected,
	output logic           busy
);
	cch_state_t  state;
	cch_state_t  next_state;
	logic        accept;
	logic        isMemWr;
	logic [5:0]  wrAddr;
	logic        wrMapped;
	logic        nvStart;
	logic        nvDone;
	logic [15:0] tempCfg;
	cch_nv_t     nvWord;

	// decode of the offered command
	assign cmdReady = (state == CCH_IDLE);
	assign accept   = clkEn && cmdValid && cmdReady;
	assign isMemWr  = (cmdIn.code >= CCH_CMD_MEMWR_BASE) && (cmdIn.code <= CCH_CMD_MEMWR_LAST);
	assign wrAddr   = 6'(cmdIn.code - CCH_CMD_MEMWR_BASE);
	assign wrMapped = isMemWr && ((wrAddr == CCH_ADDR_ID_LOW) || (wrAddr == CCH_ADDR_ID_HIGH)
		|| (wrAddr == CCH_ADDR_PRI_SETUP) || (wrAddr == CCH_ADDR_ALT_SETUP));
	assign nvStart  = accept && wrMapped;
	assign nvWord   = '{addr: wrAddr, data: cmdIn.data};
	assign busy     = (state != CCH_IDLE);

	// next state
	always_comb begin
		next_state = state;
		case (state)
			CCH_IDLE: begin
				if (nvStart)
					next_state = CCH_NVWR;
				else if (accept && ((cmdIn.code == CCH_CMD_SENS_STORE)
					|| (cmdIn.code == CCH_CMD_SENS_USER) || (cmdIn.code == CCH_CMD_TEMP_STORE)
					|| (cmdIn.code == CCH_CMD_TEMP_USER)))
					next_state = CCH_MEAS;
			end
			CCH_NVWR: begin
				if (nvDone)
					next_state = CCH_IDLE;
			end
			CCH_MEAS: begin
				if (measDone)
					next_state = CCH_IDLE;
			end
			default: next_state = CCH_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= CCH_IDLE;
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	// shadow copies of the identification words
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			custIdLow  <= CCH_ID_LOW_RST;
			custIdHigh <= CCH_ID_HIGH_RST;
		end else if (accept && isMemWr) begin
			if (wrAddr == CCH_ADDR_ID_LOW)
				custIdLow <= cmdIn.data;
			if (wrAddr == CCH_ADDR_ID_HIGH)
				custIdHigh <= cmdIn.data;
		end
	end

	// two setup words, written only by memory writes
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			primarySetup   <= CCH_PRI_RST;
			alternateSetup <= CCH_ALT_RST;
		end else if (accept && isMemWr) begin
			if (wrAddr == CCH_ADDR_PRI_SETUP)
				primarySetup <= cmdIn.data;
			if (wrAddr == CCH_ADDR_ALT_SETUP)
				alternateSetup <= cmdIn.data;
		end
	end

	// factory temperature configuration, fixed after reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tempCfg <= CCH_TEMP_CFG_RST;
		end
	end

	// setup selection, cleared by every reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			altSelected <= 1'b0;
		end else if (accept) begin
			if (cmdIn.code == CCH_CMD_SEL_ALT)
				altSelected <= 1'b1;
			else if (cmdIn.code == CCH_CMD_SEL_PRI)
				altSelected <= 1'b0;
		end
	end

	// active setup word seen by the front end, one coefficient set for both
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			activeSetupWord <= CCH_PRI_RST;
		end else if (clkEn) begin
			activeSetupWord <= altSelected ? alternateSetup : primarySetup;
		end
	end

	// measurement order and its start pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			measOut   <= '0;
			measStart <= 1'b0;
		end else if (clkEn) begin
			measStart <= 1'b0;
			if (accept) begin
				case (cmdIn.code)
					CCH_CMD_SENS_STORE: begin
						measOut   <= '{isTemp: 1'b0, cfgWord: primarySetup};
						measStart <= 1'b1;
					end
					CCH_CMD_SENS_USER: begin
						measOut   <= '{isTemp: 1'b0, cfgWord: cmdIn.data};
						measStart <= 1'b1;
					end
					CCH_CMD_TEMP_STORE: begin
						measOut   <= '{isTemp: 1'b1, cfgWord: tempCfg};
						measStart <= 1'b1;
					end
					CCH_CMD_TEMP_USER: begin
						measOut   <= '{isTemp: 1'b1,
							cfgWord: {CCH_TEMP_IGNORED, cmdIn.data[CCH_TEMP_KEEP_MSB:0]}};
						measStart <= 1'b1;
					end
					default: begin
						measStart <= 1'b0;
					end
				endcase
			end
		end
	end

	// error pulse for codes this block does not serve
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmdError <= 1'b0;
		end else if (clkEn) begin
			cmdError <= accept && !wrMapped && (cmdIn.code != CCH_CMD_SEL_PRI)
				&& (cmdIn.code != CCH_CMD_SEL_ALT) && (cmdIn.code != CCH_CMD_SENS_STORE)
				&& (cmdIn.code != CCH_CMD_SENS_USER) && (cmdIn.code != CCH_CMD_TEMP_STORE)
				&& (cmdIn.code != CCH_CMD_TEMP_USER);
		end
	end

	// nonvolatile programming of every mapped write
	cch_nv_writer uNv (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.start   (nvStart),
		.req     (nvWord),
		.nvAck   (nvAck),
		.nvReq   (nvReq),
		.nvOut   (nvOut),
		.done    (nvDone)
	);

	// checks on the decoded behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	id_low_write_a: assert property (accept && cmdIn.code == 8'h40 |=>
		custIdLow == $past(cmdIn.data)) else $error("low id word not written");
	id_high_write_a: assert property (accept && cmdIn.code == 8'h41 |=>
		custIdHigh == $past(cmdIn.data)) else $error("high id word not written");
	nv_follow_a: assert property (nvStart |=> nvReq && nvOut.addr == $past(wrAddr)
		&& nvOut.data == $past(cmdIn.data) && busy) else $error("nonvolatile write missing");
	sel_alt_a: assert property (accept && cmdIn.code == 8'hB1 |=> altSelected
		##1 (!clkEn || activeSetupWord == $past(alternateSetup))) else $error("alternate not active");
	sel_pri_a: assert property (accept && cmdIn.code == 8'hB0 |=> !altSelected)
		else $error("primary not selected");
	reset_sel_a: assert property ($fell(sys_rst) |-> !altSelected && state == CCH_IDLE)
		else $error("selection survived reset");
	meas_primary_a: assert property (accept && cmdIn.code == 8'hA2 |=> measStart
		&& !measOut.isTemp && measOut.cfgWord == $past(primarySetup)) else $error("A2 config wrong");
	meas_user_a: assert property (accept && cmdIn.code == 8'hA3 |=> measStart
		&& measOut.cfgWord == $past(cmdIn.data)) else $error("A3 config wrong");
	temp_int_a: assert property (accept && cmdIn.code == 8'hA6 |=> measStart
		&& measOut.isTemp && measOut.cfgWord == tempCfg) else $error("A6 config wrong");
	temp_mask_a: assert property (accept && cmdIn.code == 8'hA7 |=> measOut.isTemp
		&& measOut.cfgWord[15:12] == 4'h0 && measOut.cfgWord[11:0] == $past(cmdIn.data[11:0]))
		else $error("A7 upper bits not ignored");
	setup_keep_a: assert property (accept && (cmdIn.code == 8'hA2 || cmdIn.code == 8'hA6)
		|=> $stable(primarySetup) && $stable(alternateSetup) && busy) else $error("setup changed");
	active_word_a: assert property (clkEn && !$rose(clkEn) |=>
		activeSetupWord == $past(altSelected ? alternateSetup : primarySetup))
		else $error("active setup word stale");

	alt_then_meas_c: cover property (accept && cmdIn.code == 8'hB1 ##[1:20] measStart);
	nv_complete_c: cover property (nvStart ##[1:30] nvDone);
	temp_user_c: cover property (accept && cmdIn.code == 8'hA7 ##[1:30] measDone);
	id_pair_c: cover property (accept && cmdIn.code == 8'h40 ##[1:40] accept && cmdIn.code == 8'h41);
endmodule // cch_handler

//--- cch_nv_writer.sv
// holds one nonvolatile write request until the memory acknowledges it
`timescale 1ns/1ps
module cch_nv_writer import cch_pkg::*; (
	input  wire logic     mclk,
	input  wire logic     sys_rst,
	input  wire logic     clkEn,
	input  wire logic     start,
	input  wire cch_nv_t  req,
	input  wire logic     nvAck,
	output logic          nvReq,
	output cch_nv_t       nvOut,
	output logic          done
);
	// request level, dropped on acknowledge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			nvReq <= 1'b0;
		end else if (clkEn) begin
			if (start)
				nvReq <= 1'b1;
			else if (nvAck)
				nvReq <= 1'b0;
		end
	end

	// address and data latched at start
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			nvOut <= '0;
		end else if (clkEn && start) begin
			nvOut <= req;
		end
	end

	// one-cycle completion pulse after the acknowledge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			done <= 1'b0;
		end else if (clkEn) begin
			done <= nvReq && nvAck;
		end
	end
endmodule // cch_nv_writer

//--- cch_pkg.sv
// constants, types and commands of the calibration command handler
// Operation
// - Each written identification word lands in shadow registers and is also sent to nonvolatile memory.
// - Command 40 plus data writes the low identification word (address 00), 41 the high word (address 01).
// - Two analog setup registers exist while one coefficient set serves both of them.
// - Command B0 selects the primary setup and B1 the alternate setup as active.
// - Command A2 runs one raw sensor measurement with the primary setup stored at address 12.
// - Command A3 runs one raw sensor measurement with the host data word as its configuration.
// - Command A6 runs one raw temperature measurement with the internal temperature configuration.
// - Command A7 runs one raw temperature measurement with the host word, bits 15 to 12 forced off.
// - After reset the primary setup is the active one without any selection command.
// - Any reset drops the setup selection, so the host must send it again afterwards.
package cch_pkg;
	// command codes
	localparam logic [7:0] CCH_CMD_MEMWR_BASE = 8'h40;
	localparam logic [7:0] CCH_CMD_MEMWR_LAST = 8'h7F;
	localparam logic [7:0] CCH_CMD_SEL_PRI    = 8'hB0;
	localparam logic [7:0] CCH_CMD_SEL_ALT    = 8'hB1;
	localparam logic [7:0] CCH_CMD_SENS_STORE = 8'hA2;
	localparam logic [7:0] CCH_CMD_SENS_USER  = 8'hA3;
	localparam logic [7:0] CCH_CMD_TEMP_STORE = 8'hA6;
	localparam logic [7:0] CCH_CMD_TEMP_USER  = 8'hA7;
	// memory addresses of the words held here
	localparam logic [5:0] CCH_ADDR_ID_LOW    = 6'h00;
	localparam logic [5:0] CCH_ADDR_ID_HIGH   = 6'h01;
	localparam logic [5:0] CCH_ADDR_PRI_SETUP = 6'h12;
	localparam logic [5:0] CCH_ADDR_ALT_SETUP = 6'h16;
	// field layout of a user temperature word
	localparam int         CCH_TEMP_KEEP_MSB  = 11;
	localparam logic [3:0] CCH_TEMP_IGNORED   = 4'h0;
	// values after reset
	localparam logic [15:0] CCH_ID_LOW_RST    = 16'h0000;
	localparam logic [15:0] CCH_ID_HIGH_RST   = 16'h0000;
	localparam logic [15:0] CCH_PRI_RST       = 16'h0000;
	localparam logic [15:0] CCH_ALT_RST       = 16'h0000;
	localparam logic [15:0] CCH_TEMP_CFG_RST  = 16'h0000;

	// one host command: code byte and data word
	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] data;
	} cch_cmd_t;

	// one measurement order to the front end
	typedef struct packed {
		logic        isTemp;
		logic [15:0] cfgWord;
	} cch_meas_t;

	// one nonvolatile write
	typedef struct packed {
		logic [5:0]  addr;
		logic [15:0] data;
	} cch_nv_t;

	typedef enum logic [2:0] {
		CCH_IDLE = 3'b001,
		CCH_NVWR = 3'b010,
		CCH_MEAS = 3'b100
	} cch_state_t;
endpackage

//--- test_calibration_command_handler.sv
// self-checking bench of the calibration command handler
`timescale 1ns/1ps
module test_calibration_command_handler import cch_pkg::*;;
	logic        mclk, sys_rst, clkEn, cmdValid, cmdReady, cmdError, measStart, measDone;
	logic        nvReq, nvAck, altSelected, busy;
	cch_cmd_t    cmdIn;
	cch_meas_t   measOut;
	cch_nv_t     nvOut;
	logic [15:0] custIdLow, custIdHigh, primarySetup, alternateSetup, activeSetupWord;
	int          errorCnt, checked;

	cch_handler dut_u (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .cmdIn(cmdIn),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdError(cmdError), .measOut(measOut),
		.measStart(measStart), .measDone(measDone), .nvReq(nvReq), .nvOut(nvOut),
		.nvAck(nvAck), .custIdLow(custIdLow), .custIdHigh(custIdHigh),
		.primarySetup(primarySetup), .alternateSetup(alternateSetup),
		.activeSetupWord(activeSetupWord), .altSelected(altSelected), .busy(busy));
	cch_far_model far_u (.mclk(mclk), .sys_rst(sys_rst), .nvReq(nvReq),
		.measStart(measStart), .nvAck(nvAck), .measDone(measDone));

	// clock source
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d of %0d comparisons", errorCnt, checked);
		if (errorCnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// offer one command, hold it until taken, then look at the error pulse
	task automatic send(input logic [7:0] code, input logic [15:0] data, input logic expErr);
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		cmdIn = '{code, data};
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
		cmdValid = 1'b0;
		check(cmdError, expErr);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(busy, 1'b0);
	endtask

	task automatic t_write(input logic [7:0] code, input logic [15:0] data);
		send(code, data, 1'b0);
		check(nvReq, 1'b1);
		check(nvOut, {code[5:0], data});
		wait_idle();
		check(nvReq, 1'b0);
	endtask

	// the host keeps both setups fixed between measurements
	task automatic t_meas(input logic [7:0] code, input logic [15:0] data, input cch_meas_t exp);
		send(code, data, 1'b0);
		check(measStart, 1'b1);
		check(measOut, exp);
		@(posedge mclk);
		#1;
		check(measStart, 1'b0);
		wait_idle();
		check({primarySetup, 8'h00}, {16'hC3A5, 8'h00});
		check({alternateSetup, 8'h00}, {16'h5A3C, 8'h00});
	endtask

	task automatic t_select(input logic [7:0] code, input logic alt, input logic [15:0] word);
		send(code, 16'h0000, 1'b0);
		check(altSelected, alt);
		@(posedge mclk);
		#1;
		check(activeSetupWord, word);
	endtask

	// seven sensor and temperature pairs as taken at three chamber points, setups untouched
	task automatic t_collect();
		logic [15:0] word;
		for (int i = 0; i < 7; i++) begin
			word = 16'hF000 | (16'(i) * 16'h0111);
			t_meas(CCH_CMD_SENS_USER, word, '{1'b0, word});
			t_meas(CCH_CMD_TEMP_USER, word, '{1'b1, {4'h0, word[11:0]}});
		end
	endtask

	// with the enable low an offered selection is not taken and nothing moves
	task automatic t_freeze();
		@(posedge mclk);
		#1;
		clkEn = 1'b0;
		cmdIn = '{CCH_CMD_SEL_ALT, 16'h0000};
		cmdValid = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check(altSelected, 1'b0);
		check(busy, 1'b0);
		check(activeSetupWord, 16'hC3A5);
		clkEn = 1'b1;
		@(posedge mclk);
		#1;
		cmdValid = 1'b0;
		check(altSelected, 1'b1);
		@(posedge mclk);
		#1;
		check(activeSetupWord, 16'h5A3C);
	endtask

	task automatic t_reset();
		sys_rst = 1'b1;
		repeat (5) @(posedge mclk);
		#1 sys_rst = 1'b0;
	endtask

	// watchdog
	initial begin
		#100000;
		errorCnt++;
		summarize();
	end

	// main sequence
	initial begin
		errorCnt = 0;
		checked = 0;
		clkEn = 1'b1;
		cmdValid = 1'b0;
		cmdIn = '0;
		t_reset();
		check(altSelected, 1'b0);
		check({custIdLow, custIdHigh[7:0]}, 24'h000000);
		check(cmdReady, 1'b1);
		t_write(8'h40, 16'h1234);
		t_write(8'h41, 16'hFEDC);
		t_write(8'h52, 16'hC3A5);
		// only identification and setup words are written
		t_write(8'h56, 16'h5A3C);
		check({custIdLow, 8'h00}, {16'h1234, 8'h00});
		check({custIdHigh, 8'h00}, {16'hFEDC, 8'h00});
		check(activeSetupWord, 16'hC3A5);
		t_select(8'hB1, 1'b1, 16'h5A3C);
		t_select(8'hB0, 1'b0, 16'hC3A5);
		t_freeze();
		t_select(8'hB0, 1'b0, 16'hC3A5);
		t_meas(8'hA2, 16'hFFFF, '{1'b0, 16'hC3A5});
		t_meas(8'hA3, 16'hBEEF, '{1'b0, 16'hBEEF});
		t_meas(8'hA6, 16'h1357, '{1'b1, 16'h0000});
		t_meas(8'hA7, 16'hFFFF, '{1'b1, 16'h0FFF});
		t_collect();
		send(8'h00, 16'h0000, 1'b1);
		send(8'h45, 16'h0001, 1'b1);
		t_select(8'hB1, 1'b1, 16'h5A3C);
		t_reset();
		check(altSelected, 1'b0);
		summarize();
	end
endmodule // test_calibration_command_handler
